/* File: hw/lqa_pkg.sv */
// constants, carriers and state layout of the limit alert qualifier
// Contract
// - each undervoltage threshold is a 16-bit two's complement value in every mode.
// - four undervoltage threshold registers sit at consecutive addresses, channel 1 lowest.
// - an overcurrent alert is raised only after the selected run of conversions above limit.
// - an undercurrent alert is raised only after the selected run of conversions past limit.
// - an overpower alert is raised only after the selected run of conversions beyond limit.
// - an overvoltage alert is raised only after the selected run of conversions above limit.
// - a 2-bit sample field selects 1, 4, 8 or 16 samples for codes 00, 01, 10, 11.
// - every field of the four sample-count registers comes out of reset as 00, one sample; the undervoltage fields come from uv_sample_sel_i.
// - channel 1 uses bits 7-6 of a sample register, channel 4 bits 1-0.
// - a run counter holds until a finished conversion shows the condition has gone.
// - after an alert is cleared one conversion without the condition resets its state.
// - overpower compares magnitude of the top 24 power bits against the limit.
// - alerts act only when enabled, and enables take effect on a refresh.
package lqa_pkg;
  localparam int NCH   = 4;
  localparam int NCOND = 5;
  localparam int NALR  = NCH * NCOND;
  localparam int THR_W = 16;
  localparam int POW_W = 24;
  localparam int CNT_W = 5;
  localparam int SEL_W = 2;
  localparam int REG_W = 8;

  localparam logic [7:0] ADDR_UV_THR_FIRST = 8'h40;
  localparam logic [7:0] ADDR_UV_THR_LAST  = 8'h43;
  localparam logic [7:0] ADDR_OC_CNT       = 8'h44;
  localparam logic [7:0] ADDR_UC_CNT       = 8'h45;
  localparam logic [7:0] ADDR_OP_CNT       = 8'h46;
  localparam logic [7:0] ADDR_OV_CNT       = 8'h47;

  // condition slots; alert index is cond * NCH + channel
  localparam int COND_OC = 0;
  localparam int COND_UC = 1;
  localparam int COND_OP = 2;
  localparam int COND_OV = 3;
  localparam int COND_UV = 4;

  localparam int SEL_CH1_LSB = 6;

  localparam logic [1:0] SEL_ONE     = 2'h0;
  localparam logic [1:0] SEL_FOUR    = 2'h1;
  localparam logic [1:0] SEL_EIGHT   = 2'h2;
  localparam logic [1:0] SEL_SIXTEEN = 2'h3;

  localparam logic [CNT_W-1:0] TGT_ONE     = 5'h01;
  localparam logic [CNT_W-1:0] TGT_FOUR    = 5'h04;
  localparam logic [CNT_W-1:0] TGT_EIGHT   = 5'h08;
  localparam logic [CNT_W-1:0] TGT_SIXTEEN = 5'h10;

  localparam logic [THR_W-1:0] UV_THR_RST  = 16'h0000;
  localparam logic [REG_W-1:0] CNT_SEL_RST = 8'h00;

  typedef struct packed {
    logic signed [THR_W-1:0] vbus;
    logic signed [THR_W-1:0] vsense;
    logic signed [POW_W-1:0] power;
  } lqa_meas_s;

  typedef struct packed {
    logic signed [THR_W-1:0] oc;
    logic signed [THR_W-1:0] uc;
    logic signed [POW_W-1:0] op;
    logic signed [THR_W-1:0] ov;
  } lqa_limit_s;

  typedef struct packed {
    logic [7:0]       addr;
    logic             wr;
    logic             rd;
    logic [THR_W-1:0] wdata;
  } lqa_reg_req_s;

  typedef struct packed {
    logic [NCH-1:0][THR_W-1:0]  uv_thr;
    logic [NCH-1:0][REG_W-1:0]  sel_reg;
    logic [NALR-1:0][CNT_W-1:0] cnt;
    logic [NALR-1:0]            alert;
    logic [NALR-1:0]            en_act;
    logic [THR_W-1:0]           rdata;
    logic                       rvalid;
  } lqa_state_s;

  localparam lqa_state_s ST_RST = '{
    uv_thr:  {NCH{UV_THR_RST}},
    sel_reg: {NCH{CNT_SEL_RST}},
    default: '0
  };

  function automatic logic [CNT_W-1:0] lqa_target(input logic [SEL_W-1:0] sel);
    logic [CNT_W-1:0] t;
    t = TGT_ONE;
    case (sel)
      SEL_ONE:     t = TGT_ONE;
      SEL_FOUR:    t = TGT_FOUR;
      SEL_EIGHT:   t = TGT_EIGHT;
      SEL_SIXTEEN: t = TGT_SIXTEEN;
      default:     t = TGT_ONE;
    endcase
    return t;
  endfunction
endpackage

/* File: hw/lqa_qualifier.sv */
// limit alert qualifier: undervoltage thresholds, sample-count registers, run counters
`timescale 1ns/1ps
module lqa_qualifier
  import lqa_pkg::*;
(
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     ce_i,
  input  wire lqa_reg_req_s             reg_req_i,
  output logic      [THR_W-1:0]         reg_rdata_o,
  output logic                          reg_rvalid_o,
  input  wire logic                     conv_done_i,
  input  wire lqa_meas_s  [NCH-1:0]     meas_i,
  input  wire lqa_limit_s [NCH-1:0]     limits_i,
  input  wire logic       [REG_W-1:0]   uv_sample_sel_i,
  input  wire logic       [NALR-1:0]    alert_en_i,
  input  wire logic                     refresh_i,
  input  wire logic       [NALR-1:0]    alert_clr_i,
  output logic            [NALR-1:0]    alert_o
);

  lqa_state_s                  st;
  lqa_state_s                  next_st;
  logic [NALR-1:0]             cond;
  logic [NALR-1:0]             hit;
  logic [NALR-1:0][CNT_W-1:0]  tgt;
  logic [NALR-1:0][CNT_W-1:0]  cnt_inc;
  logic [NCOND-1:0][REG_W-1:0] sel_all;

  // the undervoltage sample register lives in a neighbouring bank
  assign sel_all = {uv_sample_sel_i, st.sel_reg};

  // per-channel comparators
  for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
    logic signed [POW_W:0] pw;
    logic signed [POW_W:0] lim;
    logic signed [POW_W:0] nlim;
    // one extra bit so negating the most negative limit cannot wrap
    assign pw   = {meas_i[ch].power[POW_W-1], meas_i[ch].power};
    assign lim  = {limits_i[ch].op[POW_W-1], limits_i[ch].op};
    assign nlim = -lim;
    assign cond[COND_OC*NCH+ch] = meas_i[ch].vsense > limits_i[ch].oc;
    assign cond[COND_UC*NCH+ch] = meas_i[ch].vsense < limits_i[ch].uc;
    assign cond[COND_OP*NCH+ch] = (pw > lim) || (pw < nlim);
    assign cond[COND_OV*NCH+ch] = meas_i[ch].vbus > limits_i[ch].ov;
    assign cond[COND_UV*NCH+ch] = meas_i[ch].vbus < $signed(st.uv_thr[ch]);

    // per-condition field select for this channel
    for (genvar c = 0; c < NCOND; c++) begin : g_cond
      assign tgt[c*NCH+ch] =
        lqa_target(sel_all[c][SEL_CH1_LSB-SEL_W*ch +: SEL_W]);
    end

    AST_OP_NEG_TRIP: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && conv_done_i && st.en_act[COND_OP*NCH+ch]
      && tgt[COND_OP*NCH+ch] == TGT_ONE && pw < nlim
      |=> alert_o[COND_OP*NCH+ch])
      else $error("negative overpower beyond limit did not raise alert");

    AST_UV_BELOW: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && conv_done_i && st.en_act[COND_UV*NCH+ch]
      && tgt[COND_UV*NCH+ch] == TGT_ONE
      && meas_i[ch].vbus < $signed(st.uv_thr[ch])
      |=> alert_o[COND_UV*NCH+ch])
      else $error("bus voltage below threshold did not raise alert");
  end

  // run counters, saturating at the largest selectable count
  for (genvar k = 0; k < NALR; k++) begin : g_alr
    assign cnt_inc[k] = (st.cnt[k] < TGT_SIXTEEN) ? CNT_W'(st.cnt[k] + 1'b1) : st.cnt[k];
    assign hit[k]     = cond[k] && st.en_act[k] && (cnt_inc[k] >= tgt[k]);

    AST_ALERT_STICKY: assert property (@(posedge clk_i) disable iff (rst_i)
      alert_o[k] && !(ce_i && alert_clr_i[k]) |=> alert_o[k])
      else $error("alert dropped without a clear");

    AST_CLEAR_DROPS: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && alert_clr_i[k] && !(conv_done_i && hit[k]) |=> !alert_o[k])
      else $error("cleared alert stayed raised");

    AST_RUN_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && conv_done_i && !cond[k] |=> st.cnt[k] == '0)
      else $error("clean conversion did not restart its run");

    AST_RUN_STEP: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && conv_done_i && cond[k] && st.cnt[k] < TGT_SIXTEEN
      |=> st.cnt[k] == $past(st.cnt[k]) + 5'h01)
      else $error("run counter did not advance on a qualifying conversion");

    AST_NO_EARLY: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(alert_o[k]) |-> $past(st.cnt[k]) + 5'h01 >= $past(tgt[k]))
      else $error("alert rose before its run reached the selected count");
  end

  always_comb begin
    next_st = st;
    if (ce_i) begin
      // the answer pulse is frozen with the rest of the state while ce_i is low
      next_st.rvalid = 1'b0;
      // register writes; the host is expected to have disabled alerts first
      if (reg_req_i.wr) begin
        case (reg_req_i.addr)
          ADDR_OC_CNT: next_st.sel_reg[COND_OC] = reg_req_i.wdata[REG_W-1:0];
          ADDR_UC_CNT: next_st.sel_reg[COND_UC] = reg_req_i.wdata[REG_W-1:0];
          ADDR_OP_CNT: next_st.sel_reg[COND_OP] = reg_req_i.wdata[REG_W-1:0];
          ADDR_OV_CNT: next_st.sel_reg[COND_OV] = reg_req_i.wdata[REG_W-1:0];
          default: begin
            if (reg_req_i.addr >= ADDR_UV_THR_FIRST && reg_req_i.addr <= ADDR_UV_THR_LAST) begin
              next_st.uv_thr[reg_req_i.addr[1:0]] = reg_req_i.wdata;
            end
          end
        endcase
      end
      // reads answer one cycle later; unmapped addresses read zero
      if (reg_req_i.rd) begin
        next_st.rvalid = 1'b1;
        case (reg_req_i.addr)
          ADDR_OC_CNT: next_st.rdata = {8'h00, st.sel_reg[COND_OC]};
          ADDR_UC_CNT: next_st.rdata = {8'h00, st.sel_reg[COND_UC]};
          ADDR_OP_CNT: next_st.rdata = {8'h00, st.sel_reg[COND_OP]};
          ADDR_OV_CNT: next_st.rdata = {8'h00, st.sel_reg[COND_OV]};
          default: begin
            if (reg_req_i.addr >= ADDR_UV_THR_FIRST && reg_req_i.addr <= ADDR_UV_THR_LAST) begin
              next_st.rdata = st.uv_thr[reg_req_i.addr[1:0]];
            end else begin
              next_st.rdata = '0;
            end
          end
        endcase
      end
      if (refresh_i) begin
        next_st.en_act = alert_en_i;
      end
      next_st.alert = st.alert & ~alert_clr_i;
      if (conv_done_i) begin
        for (int k = 0; k < NALR; k++) begin
          if (cond[k]) begin
            next_st.cnt[k] = cnt_inc[k];
            // a qualifying conversion beats a clear in the same cycle
            if (hit[k]) begin
              next_st.alert[k] = 1'b1;
            end
          end else begin
            // only a finished conversion may restart the run
            next_st.cnt[k] = '0;
          end
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= ST_RST;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata_o  = st.rdata;
  assign reg_rvalid_o = st.rvalid;
  assign alert_o      = st.alert;

  sequence s_read_uv(int idx);
    ce_i && reg_req_i.rd && !reg_req_i.wr
    && reg_req_i.addr == ADDR_UV_THR_FIRST + 8'(idx);
  endsequence

  sequence s_quiet_cycle;
    !ce_i || !conv_done_i;
  endsequence

  AST_UV_READBACK: assert property (@(posedge clk_i) disable iff (rst_i)
    s_read_uv(3) |=> reg_rvalid_o && reg_rdata_o == st.uv_thr[3])
    else $error("channel 4 threshold did not read back from the last address");

  AST_SEL_RESET: assert property (@(posedge clk_i)
    $past(rst_i) && !rst_i |-> st.sel_reg == {NCH{CNT_SEL_RST}} && alert_o == '0)
    else $error("sample fields not at one-sample setting after reset");

  AST_DECODE_FOUR: assert property (@(posedge clk_i) disable iff (rst_i)
    st.sel_reg[COND_OC][SEL_CH1_LSB-SEL_W +: SEL_W] == SEL_FOUR
    |-> tgt[COND_OC*NCH+1] == TGT_FOUR)
    else $error("code 01 did not select four samples");

  AST_FIELD_CH4: assert property (@(posedge clk_i) disable iff (rst_i)
    st.sel_reg[COND_OV][SEL_W-1:0] == SEL_SIXTEEN
    |-> tgt[COND_OV*NCH+NCH-1] == TGT_SIXTEEN)
    else $error("channel 4 did not take its field from bits 1-0");

  AST_CNT_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    s_quiet_cycle |=> $stable(st.cnt))
    else $error("run counter moved without a finished conversion");

  AST_CNT_RESTART: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && conv_done_i && !cond[COND_OC*NCH] |=> st.cnt[COND_OC*NCH] == '0)
    else $error("clear conversion did not restart run counter");

  AST_OC_QUAL: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(alert_o[COND_OC*NCH])
    |-> $past(ce_i && conv_done_i && cond[COND_OC*NCH]
              && cnt_inc[COND_OC*NCH] >= tgt[COND_OC*NCH]))
    else $error("overcurrent alert rose without a full run");

  AST_UC_QUAL: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(alert_o[COND_UC*NCH+1])
    |-> $past(conv_done_i && cond[COND_UC*NCH+1]
              && cnt_inc[COND_UC*NCH+1] >= tgt[COND_UC*NCH+1]))
    else $error("undercurrent alert rose without a full run");

  AST_OP_QUAL: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(alert_o[COND_OP*NCH+2]) |-> $past(cond[COND_OP*NCH+2] && conv_done_i)
    ##0 $past(st.cnt[COND_OP*NCH+2]) + 5'h01 >= $past(tgt[COND_OP*NCH+2]))
    else $error("overpower alert rose without a full run");

  AST_OV_SIXTEEN: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(alert_o[COND_OV*NCH+3]) && $past(tgt[COND_OV*NCH+3]) == TGT_SIXTEEN
    |-> $past(st.cnt[COND_OV*NCH+3]) >= 5'h0f)
    else $error("overvoltage alert at sixteen rose early");

  AST_EN_GATE: assert property (@(posedge clk_i) disable iff (rst_i)
    !st.en_act[COND_UV*NCH] && !alert_o[COND_UV*NCH] |=> !alert_o[COND_UV*NCH])
    else $error("disabled alert was raised");

  AST_SET_WINS: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && conv_done_i && hit[0] && alert_clr_i[0] |=> alert_o[0])
    else $error("alert lost when set and clear met");

  // a frozen cycle is not a finished conversion, so nothing may move at all
  AST_CE_FREEZE: assert property (@(posedge clk_i) disable iff (rst_i)
    !ce_i |=> $stable(st))
    else $error("state moved while the clock enable was low");

  AST_RVALID_AFTER_RD: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && reg_req_i.rd |=> reg_rvalid_o)
    else $error("read was not answered in the next cycle");

  AST_RVALID_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !reg_req_i.rd |=> !reg_rvalid_o)
    else $error("read answer stood longer than one cycle");

  AST_UNMAPPED_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && reg_req_i.rd
    && (reg_req_i.addr < ADDR_UV_THR_FIRST || reg_req_i.addr > ADDR_OV_CNT)
    |=> reg_rdata_o == '0)
    else $error("unmapped address did not read zero");

  AST_REFRESH_COPY: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && refresh_i |=> st.en_act == $past(alert_en_i))
    else $error("refresh did not copy the enables");

  AST_EN_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    !refresh_i |=> $stable(st.en_act))
    else $error("active enables changed without a refresh");

  // register map checks, one set per sample-count register and threshold
  for (genvar r = 0; r < COND_UV; r++) begin : g_regchk
    AST_SEL_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && reg_req_i.wr && reg_req_i.addr == ADDR_OC_CNT + 8'(r)
      |=> st.sel_reg[r] == $past(reg_req_i.wdata[REG_W-1:0]))
      else $error("sample-count write did not land in its register");

    AST_SEL_READ: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && reg_req_i.rd && reg_req_i.addr == ADDR_OC_CNT + 8'(r)
      |=> reg_rdata_o == {8'h00, $past(st.sel_reg[r])})
      else $error("sample-count read did not return its register");

    AST_UV_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && reg_req_i.wr && reg_req_i.addr == ADDR_UV_THR_FIRST + 8'(r)
      |=> st.uv_thr[r] == $past(reg_req_i.wdata))
      else $error("threshold write did not land at its channel");

    AST_UV_READ: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && reg_req_i.rd && reg_req_i.addr == ADDR_UV_THR_FIRST + 8'(r)
      |=> reg_rdata_o == $past(st.uv_thr[r]))
      else $error("threshold read did not return its channel");
  end

endmodule

/* File: test/lqa_host_model.sv */
// host side model: register requests, alert enables, refresh and clears
`timescale 1ns/1ps
module lqa_host_model
  import lqa_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic [THR_W-1:0] rdata_i,
  input  wire logic             rvalid_i,
  output lqa_reg_req_s          req_o,
  output logic      [NALR-1:0]  en_o,
  output logic                  refresh_o,
  output logic      [NALR-1:0]  clr_o
);
  initial begin
    req_o = '0;
    en_o = '0;
    refresh_o = 1'b0;
    clr_o = '0;
  end

  task automatic step();
    @(posedge clk_i);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [THR_W-1:0] d);
    step();
    req_o = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    step();
    req_o.wr = 1'b0;
  endtask

  // read data is taken in the cycle the answer stands, never later
  task automatic rd(input logic [7:0] a, output logic [THR_W-1:0] d);
    step();
    req_o = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: '0};
    step();
    req_o.rd = 1'b0;
    d = rvalid_i ? rdata_i : 'x;
  endtask

  // callers pass zero first so no alert fires while a setting is rewritten
  task automatic arm(input logic [NALR-1:0] e);
    step();
    en_o = e;
    refresh_o = 1'b1;
    step();
    refresh_o = 1'b0;
  endtask

  task automatic clr(input int b);
    step();
    clr_o = NALR'(1) << b;
    step();
    clr_o = '0;
  endtask
endmodule

/* File: test/tb.sv */
// self-checking bench of the limit alert qualifier
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin miscompares++; \
  $display("ERROR at %0t: got %h expected %h", $time, a, e); end end
module tb;
  import lqa_pkg::*;
  logic                   clk_i = 1'b0;
  logic                   rst_i;
  logic                   ce_i;
  logic                   conv;
  lqa_meas_s  [NCH-1:0]   meas;
  lqa_limit_s [NCH-1:0]   lim;
  logic       [REG_W-1:0] uv_sel;
  lqa_reg_req_s           req;
  logic       [THR_W-1:0] rdata;
  logic                   rvalid;
  logic       [NALR-1:0]  en;
  logic       [NALR-1:0]  clr;
  logic       [NALR-1:0]  alert;
  logic                   refresh;
  int                     miscompares = 0;
  int                     comparisons = 0;

  always #4 clk_i = ~clk_i;

  lqa_qualifier uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .reg_req_i(req),
    .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .conv_done_i(conv), .meas_i(meas),
    .limits_i(lim), .uv_sample_sel_i(uv_sel), .alert_en_i(en), .refresh_i(refresh),
    .alert_clr_i(clr), .alert_o(alert));

  lqa_host_model host (.clk_i(clk_i), .rdata_i(rdata), .rvalid_i(rvalid), .req_o(req),
    .en_o(en), .refresh_o(refresh), .clr_o(clr));

  // only one quantity leaves its quiet band, so one condition per run
  function automatic lqa_meas_s hot(input int c);
    lqa_meas_s m;
    m = '0;
    case (c)
      0: m.vsense = 16'h00c8;
      1: m.vsense = 16'hff38;
      2: m.power = 24'hfff830;
      3: m.vbus = 16'h012c;
      default: m.vbus = 16'hffc4;
    endcase
    return m;
  endfunction

  task automatic conv_step(input lqa_meas_s m);
    @(posedge clk_i);
    #1;
    meas = {NCH{m}};
    conv = 1'b1;
    @(posedge clk_i);
    #1;
    conv = 1'b0;
    meas = '0;
  endtask

  task automatic regs();
    logic [THR_W-1:0] d;
    for (int a = 0; a < 8; a++) begin
      host.rd(8'(8'h40 + a), d);
      `CHK(d, 16'h0000)
    end
    host.rd(8'h50, d);
    `CHK(d, 16'h0000)
    for (int i = 0; i < NCH; i++) begin
      host.wr(8'(8'h40 + i), 16'(16'hffce - i));
      host.wr(8'(8'h44 + i), 16'hff1b);
    end
    // with the clock enable low this write must be ignored, so 0x40 keeps its value
    ce_i = 1'b0;
    host.wr(8'h40, 16'h1234);
    ce_i = 1'b1;
    for (int i = 0; i < NCH; i++) begin
      host.rd(8'(8'h40 + i), d);
      `CHK(d, 16'(16'hffce - i))
      host.rd(8'(8'h44 + i), d);
      `CHK(d, 16'h001b)
    end
  endtask

  task automatic run(input int c);
    int ch;
    int sel;
    int n;
    int b;
    logic [REG_W-1:0] f;
    logic [NALR-1:0] exp1;
    ch = c % NCH;
    sel = c % 4;
    n = (sel == 0) ? 1 : (2 << sel);
    b = c * NCH + ch;
    exp1 = NALR'(1) << b;
    f = REG_W'(sel) << (6 - 2 * ch);
    host.arm('0);
    if (c == COND_UV) uv_sel = f;
    else host.wr(8'(8'h44 + c), {8'h00, f});
    // a disabled alert stays low; the clean conversion after it restarts the run
    conv_step(hot(c));
    `CHK(alert, '0)
    conv_step('0);
    host.arm(exp1);
    for (int k = 1; k <= n; k++) begin
      repeat (3) @(posedge clk_i);
      conv_step(hot(c));
      `CHK(alert, exp1 & {NALR{k == n}})
    end
    // a qualifying conversion and a clear in one cycle: the set wins
    fork
      host.clr(b);
      conv_step(hot(c));
    join
    `CHK(alert, exp1)
    host.clr(b);
    conv_step(hot(c));
    `CHK(alert, exp1)
    conv_step('0);
    host.clr(b);
    `CHK(alert, '0)
    repeat (n - 1) conv_step(hot(c));
    `CHK(alert, '0)
  endtask

  // magnitude trip on both signs at the one-sample setting
  task automatic op_magnitude();
    lqa_meas_s m;
    logic [NALR-1:0] bit_op;
    bit_op = NALR'(1) << (COND_OP * NCH);
    m = '0;
    m.power = 24'h0007d0;
    host.arm('0);
    host.wr(ADDR_OP_CNT, 16'h0000);
    host.arm(bit_op);
    conv_step(hot(COND_OP));
    `CHK(alert, bit_op)
    host.clr(COND_OP * NCH);
    conv_step(m);
    `CHK(alert, bit_op)
    conv_step('0);
    host.clr(COND_OP * NCH);
    `CHK(alert, '0)
  endtask

  task automatic give_verdict();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    rst_i = 1'b1;
    ce_i = 1'b1;
    conv = 1'b0;
    meas = '0;
    uv_sel = '0;
    for (int i = 0; i < NCH; i++) begin
      lim[i] = '{oc: 16'h0064, uc: 16'hff9c, op: 24'h0003e8, ov: 16'h00c8};
    end
    repeat (6) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    regs();
    for (int c = 0; c < NCOND; c++) run(c);
    op_magnitude();
    give_verdict();
  end

  // the full sequence needs well under a tenth of this span
  initial begin
    #100000;
    miscompares++;
    give_verdict();
  end
endmodule
